//--- logic/dcc_top.sv
// Dual comparator control: APB registers, mode control, change flag and pin muxing.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "dcc_defines.svh"
// ---------------------------------------------------------------
// Notes on behaviour
// ---------------------------------------------------------------
// Notes on behaviour
// - Eight modes from three-bit mode field.
// - Output invalid until settle delay after mode change.
// - Result high when positive input exceeds negative.
// - Mode 010 routes internal reference to positive.
// - Results read at bits 7:6, read-only.
// - Mode 110 drives raw results onto pins.
// - Direction bits still gate those pin drivers.
// - Analog-input pins read zero from port data.
// - Flag sets when result differs from sample.
// - Software writes zero clears, one sets flag.
// - Request needs all three enables; flag always.
// - Change during control read still sets flag.
// - Control access refreshes sampled result copy.
// - Persisting mismatch keeps setting the flag.
// - Active comparator wakes device from sleep.
// - Mode 111 powers both comparators off.
// - Wake leaves control register unchanged.
// - Reset: mode 000, analog pins, comparators off.
// - Control holds results, inverts, switch, mode.
module dcc_top
   import dcc_pkg::*;
#(
   parameter int SETTLE_NS = `DCC_MODE_SETTLE_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] cmp_raw,
   input wire logic sleeping,
   input wire logic [7:0] port_pin_in,
   output dcc_analog_t analog_ctrl_r,
   output logic [1:0] result_pin_out_r,
   output logic [1:0] result_pin_oe_r,
   output logic irq_req_r,
   output logic wake_req_r,
   output logic mode_valid_r
);

   localparam int SETTLE_CYC_I = (SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS;
   localparam int SETTLE_CYC = (SETTLE_CYC_I < 1) ? 1 : SETTLE_CYC_I;
   localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   dcc_ctrl_t ctrl_r;
   logic [1:0] sampled_r;
   logic flag_r;
   logic [9:6] ien_r;
   logic [7:0] dir_r;
   logic [7:0] pdat_r;
   dcc_state_t state_r;
   logic [15:0] settle_cnt_r;
   logic [1:0] cmp_sync;
   logic [1:0] result;
   logic cmp_on;
   logic access;
   logic wr;
   logic ctrl_hit;
   logic mode_change;
   logic [31:0] rdata_nxt;
   logic slverr_nxt;

   dcc_sync #(
      .WIDTH(2)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(cmp_raw),
      .sync_out(cmp_sync)
   );

   // Zero wait states: every access completes in its first access cycle.
   assign access = psel && penable && pready;
   assign wr = access && pwrite;
   assign ctrl_hit = access && (paddr == `DCC_CTRL_OFS);
   assign cmp_on = (ctrl_r.comparator_mode_field != DCC_MODE_RESET) &&
                   (ctrl_r.comparator_mode_field != DCC_MODE_OFF);
   assign mode_change = wr && (paddr == `DCC_CTRL_OFS) &&
      (pwdata[`DCC_CTRL_MODE_HI:`DCC_CTRL_MODE_LO] != ctrl_r.comparator_mode_field);

   // Comparator polarity is analog; invert bits apply after synchronising.
   // Results of a powered-down pair read as zero.
   assign result = cmp_on ? (cmp_sync ^ {ctrl_r.invert2, ctrl_r.invert1}) : 2'b00;

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   // Sleep has no path into this register, so wake keeps it intact.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= dcc_ctrl_t'(`DCC_CTRL_RST);
      end else if (wr && paddr == `DCC_CTRL_OFS) begin
         ctrl_r <= dcc_ctrl_t'(pwdata[5:0]);
      end
   end

   // ---------------------------------------------------------------
   // Mode-change settling
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= DCC_ST_IDLE;
         settle_cnt_r <= 16'h0000;
         mode_valid_r <= 1'b0;
      end else begin
         unique case (state_r)
            DCC_ST_IDLE: begin
               if (mode_change) begin
                  state_r <= DCC_ST_SETTLE;
                  settle_cnt_r <= 16'h0000;
                  mode_valid_r <= 1'b0;
               end else begin
                  mode_valid_r <= cmp_on;
               end
            end
            DCC_ST_SETTLE: begin
               if (mode_change) begin
                  settle_cnt_r <= 16'h0000;
               end else if (settle_cnt_r == SETTLE_LAST) begin
                  state_r <= DCC_ST_IDLE;
               end else begin
                  settle_cnt_r <= settle_cnt_r + 16'h0001;
               end
            end
            default: begin
               state_r <= DCC_ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Change detection and flag
   // ---------------------------------------------------------------
   // The sampled copy is refreshed by any control access, which ends the
   // mismatch; a change landing in that same cycle still sets the flag against the old copy.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sampled_r <= 2'b00;
      end else if (ctrl_hit) begin
         sampled_r <= result;
      end
   end

   // Hardware set wins over a software clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else if (result != sampled_r) begin
         flag_r <= 1'b1;
      end else if (wr && paddr == `DCC_FLAG_OFS) begin
         flag_r <= pwdata[`DCC_FLAG_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Enables, port direction and data
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_r <= 4'h0;
      end else if (wr && paddr == `DCC_IEN_OFS) begin
         ien_r <= pwdata[9:6];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= `DCC_DIR_RST;
         pdat_r <= `DCC_DAT_RST;
      end else begin
         if (wr && paddr == `DCC_PDIR_OFS) begin
            dir_r <= pwdata[7:0];
         end
         if (wr && paddr == `DCC_PDAT_OFS) begin
            pdat_r <= pwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs towards the analog block, pins and core
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_ctrl_r <= '0;
      end else begin
         analog_ctrl_r.power_on <= cmp_on;
         analog_ctrl_r.int_ref_sel <= (ctrl_r.comparator_mode_field == DCC_MODE_INT_REF);
         analog_ctrl_r.input_switch_bit <= ctrl_r.input_switch_bit;
         analog_ctrl_r.mode <= ctrl_r.comparator_mode_field;
      end
   end

   // The pin path carries the raw comparator level on purpose; it is only
   // retimed by this flop, not synchronised.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_pin_out_r <= 2'b00;
         result_pin_oe_r <= 2'b00;
      end else begin
         if (ctrl_r.comparator_mode_field == DCC_MODE_PIN_OUT) begin
            result_pin_out_r <= cmp_raw ^ {ctrl_r.invert2, ctrl_r.invert1};
         end else begin
            result_pin_out_r <= {pdat_r[`DCC_DIR_PIN2], pdat_r[`DCC_DIR_PIN1]};
         end
         result_pin_oe_r <= ~{dir_r[`DCC_DIR_PIN2], dir_r[`DCC_DIR_PIN1]};
      end
   end

   // Software is expected to drop the comparator enable around mode writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req_r <= 1'b0;
         wake_req_r <= 1'b0;
      end else begin
         irq_req_r <= flag_r && ien_r[`DCC_IEN_CMP] && ien_r[`DCC_IEN_PERI] &&
                      ien_r[`DCC_IEN_GLOB];
         wake_req_r <= sleeping && flag_r && ien_r[`DCC_IEN_CMP];
      end
   end

   // ---------------------------------------------------------------
   // APB read path
   // ---------------------------------------------------------------
   // Pins still owned by the comparator inputs are analog and read zero.
   function automatic logic [7:0] analog_mask(input dcc_mode_t m);
      logic [7:0] msk;
      msk = 8'h00;
      unique case (m)
         DCC_MODE_RESET, DCC_MODE_FOUR_IN, DCC_MODE_INT_REF: msk = 8'h0F;
         DCC_MODE_ONE_IND, DCC_MODE_TWO_IND, DCC_MODE_PIN_OUT: msk = 8'h07;
         DCC_MODE_TWO_CMN: msk = 8'h03;
         DCC_MODE_OFF: msk = 8'h00;
      endcase
      return msk;
   endfunction

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      slverr_nxt = 1'b0;
      unique case (paddr)
         `DCC_CTRL_OFS: rdata_nxt[7:0] = {result, 6'(ctrl_r)};
         `DCC_FLAG_OFS: rdata_nxt[`DCC_FLAG_BIT] = flag_r;
         `DCC_IEN_OFS: rdata_nxt[9:6] = ien_r;
         `DCC_PDIR_OFS: rdata_nxt[7:0] = dir_r;
         `DCC_PDAT_OFS: rdata_nxt[7:0] = port_pin_in &
                                        ~analog_mask(ctrl_r.comparator_mode_field);
         `DCC_STAT_OFS: rdata_nxt[3:0] = {state_r == DCC_ST_SETTLE, cmp_on, sampled_r};
         default: slverr_nxt = 1'b1;
      endcase
   end

   // Read data is registered during setup so the access phase sees it at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr <= slverr_nxt;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule

//--- logic/dcc_defines.svh
// Register offsets, field positions, reset values and timings in nanoseconds of the comparator control.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Register byte offsets on the APB slave.
`define DCC_CTRL_OFS 12'h07C
`define DCC_FLAG_OFS 12'h080
`define DCC_IEN_OFS 12'h084
`define DCC_PDIR_OFS 12'h088
`define DCC_PDAT_OFS 12'h08C
`define DCC_STAT_OFS 12'h090

// Control register fields.
`define DCC_CTRL_RES2 7
`define DCC_CTRL_RES1 6
`define DCC_CTRL_INV2 5
`define DCC_CTRL_INV1 4
`define DCC_CTRL_CIS 3
`define DCC_CTRL_MODE_HI 2
`define DCC_CTRL_MODE_LO 0

// Flag, enable and direction fields.
`define DCC_FLAG_BIT 6
`define DCC_IEN_CMP 6
`define DCC_IEN_PERI 7
`define DCC_IEN_GLOB 8
`define DCC_IEN_SLEEP 9
`define DCC_DIR_PIN1 3
`define DCC_DIR_PIN2 4

// Reset values.
`define DCC_CTRL_RST 8'h00
`define DCC_DIR_RST 8'hFF
`define DCC_DAT_RST 8'h00

// Settling after a mode change, in nanoseconds.
`define DCC_MODE_SETTLE_NS 10000
`define DCC_CLK_NS 40

`endif

//--- logic/dcc_pkg.sv
// Types shared by the comparator control files.
package dcc_pkg;

   typedef enum logic [2:0] {
      DCC_MODE_RESET = 3'h0,
      DCC_MODE_ONE_IND = 3'h1,
      DCC_MODE_INT_REF = 3'h2,
      DCC_MODE_FOUR_IN = 3'h3,
      DCC_MODE_TWO_CMN = 3'h4,
      DCC_MODE_TWO_IND = 3'h5,
      DCC_MODE_PIN_OUT = 3'h6,
      DCC_MODE_OFF = 3'h7
   } dcc_mode_t;

   typedef struct packed {
      logic invert2;
      logic invert1;
      logic input_switch_bit;
      dcc_mode_t comparator_mode_field;
   } dcc_ctrl_t;

   typedef struct packed {
      logic power_on;
      logic int_ref_sel;
      logic input_switch_bit;
      dcc_mode_t mode;
   } dcc_analog_t;

   typedef enum logic [1:0] {
      DCC_ST_IDLE = 2'b01,
      DCC_ST_SETTLE = 2'b10
   } dcc_state_t;

endpackage

//--- logic/dcc_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/10ps
module dcc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

//--- tb/dcc_cmp_model.sv
// Behavioural model of the two analog comparators beside the block.
`timescale 1ns/10ps
module dcc_cmp_model
   import dcc_pkg::*;
#(
   parameter logic [7:0] INT_REF = 8'h80
) (
   input wire logic [1:0][7:0] vpos,
   input wire logic [1:0][7:0] vneg,
   input wire dcc_analog_t actl,
   output logic [1:0] cmp_raw
);
   logic [1:0][7:0] pos;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pos[i] = actl.int_ref_sel ? INT_REF : vpos[i];
         cmp_raw[i] = actl.power_on && (pos[i] > vneg[i]);
      end
   end
endmodule

//--- tb/dcc_top_props.sv
// Checker of port-level relations of the comparator control.
`timescale 1ns/10ps
`include "dcc_defines.svh"
module dcc_top_props
   import dcc_pkg::*;
#(
   parameter int SETTLE_NS = `DCC_MODE_SETTLE_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleeping,
   input wire dcc_analog_t analog_ctrl_r,
   input wire logic [1:0] result_pin_oe_r,
   input wire logic irq_req_r,
   input wire logic wake_req_r,
   input wire logic mode_valid_r
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   logic wr_ctl;
   assign mapped = paddr inside {12'h07C, 12'h080, 12'h084, 12'h088, 12'h08C, 12'h090};
   assign wr_ctl = psel && penable && pwrite && paddr == `DCC_CTRL_OFS;
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_err;
      pready |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("wrong error response");
   property p_rdzero;
      pready && !pwrite && pslverr |-> prdata == 32'h0;
   endproperty
   a_rdzero: assert property (p_rdzero) else $error("refused read not zero");
   property p_res;
      pready && !pwrite && paddr == `DCC_CTRL_OFS && (analog_ctrl_r.mode inside
         {DCC_MODE_RESET, DCC_MODE_OFF}) |-> prdata[7:6] == 2'b00;
   endproperty
   a_res: assert property (p_res) else $error("results set while off");
   property p_ref;
      analog_ctrl_r.int_ref_sel == (analog_ctrl_r.mode == DCC_MODE_INT_REF);
   endproperty
   a_ref: assert property (p_ref) else $error("reference select wrong");
   property p_off;
      analog_ctrl_r.mode == DCC_MODE_OFF |-> !analog_ctrl_r.power_on && !mode_valid_r;
   endproperty
   a_off: assert property (p_off) else $error("powered in off mode");
   property p_ctl;
      !$stable(analog_ctrl_r) |-> $past(wr_ctl) || $past(wr_ctl, 2);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control changed unwritten");
   property p_settle;
      $changed(analog_ctrl_r.mode) |-> ##1 !mode_valid_r [*3];
   endproperty
   a_settle: assert property (p_settle) else $error("valid too soon");
   property p_mv;
      mode_valid_r |-> analog_ctrl_r.power_on;
   endproperty
   a_mv: assert property (p_mv) else $error("valid while unpowered");
   property p_wake;
      wake_req_r |-> $past(sleeping);
   endproperty
   a_wake: assert property (p_wake) else $error("wake while awake");
   c_err: cover property (pready && pslverr);
   c_pin: cover property (analog_ctrl_r.mode == DCC_MODE_PIN_OUT && result_pin_oe_r != 0);
   c_irq: cover property (irq_req_r);
   c_wake: cover property (wake_req_r);
endmodule
bind dcc_top dcc_top_props #(.SETTLE_NS(SETTLE_NS)) u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sleeping(sleeping), .analog_ctrl_r(analog_ctrl_r),
   .result_pin_oe_r(result_pin_oe_r), .irq_req_r(irq_req_r), .wake_req_r(wake_req_r),
   .mode_valid_r(mode_valid_r));

//--- tb/dcc_top_bench.sv
// Self-checking bench of the comparator control.
`timescale 1ns/10ps
`include "dcc_defines.svh"
module dcc_top_bench;
   import dcc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleeping = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, lf = 32'h8A8E2779;
   logic pready, pslverr, err, irq, wake, mv;
   logic [1:0] cmp_raw, pout, poe;
   logic [7:0] pins = 0;
   logic [1:0][7:0] vpos = 0;
   // Full-scale negative inputs keep every raw result low.
   logic [1:0][7:0] vneg = 16'hFFFF;
   dcc_analog_t actl;
   int bad_count = 0, checks = 0;
   always #20 pclk = ~pclk;
   dcc_top #(.SETTLE_NS(200)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .sleeping(sleeping),
      .port_pin_in(pins), .analog_ctrl_r(actl), .result_pin_out_r(pout),
      .result_pin_oe_r(poe), .irq_req_r(irq), .wake_req_r(wake), .mode_valid_r(mv));
   dcc_cmp_model CMP (.vpos(vpos), .vneg(vneg), .actl(actl), .cmp_raw(cmp_raw));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [7:0] pmask(input logic [2:0] m);
      case (m)
         3'h0, 3'h2, 3'h3: return 8'h0F;
         3'h1, 3'h5, 3'h6: return 8'h07;
         3'h4: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) begin
         bad_count++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic [2:0] m;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, `DCC_CTRL_OFS, 0);
      chk(rd, 32'h0);
      apb(0, `DCC_PDIR_OFS, 0);
      chk(rd, 32'hFF);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         m = i[2:0];
         v = {2'b11, lf[1:0], 1'b0, m};
         pins <= lf[15:8];
         apb(1, `DCC_CTRL_OFS, {24'h0, v});
         // The analog control word is launched at the edge the write task ends on.
         @(posedge pclk);
         chk(32'(actl.mode), 32'(m));
         apb(0, `DCC_CTRL_OFS, 0);
         chk(rd, {24'h0, (m == 0 || m == 7) ? 2'b00 : v[5:4], v[5:0]});
         apb(0, `DCC_PDAT_OFS, 0);
         chk(rd, {24'h0, pins & ~pmask(m)});
      end
      $display("mode test done");
      vneg <= 16'h4040;
      apb(1, `DCC_CTRL_OFS, 32'h05);
      apb(1, `DCC_IEN_OFS, 32'h1C0);
      repeat (10) @(posedge pclk);
      apb(0, `DCC_CTRL_OFS, 0);
      apb(1, `DCC_FLAG_OFS, 0);
      apb(0, `DCC_FLAG_OFS, 0);
      chk(rd, 32'h0);
      vpos <= 16'h8000;
      repeat (8) @(posedge pclk);
      apb(0, `DCC_FLAG_OFS, 0);
      chk(rd, 32'h40);
      chk(32'(irq), 32'h1);
      apb(1, `DCC_FLAG_OFS, 0);
      apb(0, `DCC_FLAG_OFS, 0);
      chk(rd, 32'h40);
      apb(0, `DCC_CTRL_OFS, 0);
      chk(rd, 32'h85);
      apb(1, `DCC_FLAG_OFS, 0);
      apb(0, `DCC_FLAG_OFS, 0);
      chk(rd, 32'h0);
      apb(1, `DCC_FLAG_OFS, 32'h40);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1, `DCC_IEN_OFS, 32'h0C0);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      sleeping <= 1;
      repeat (3) @(posedge pclk);
      chk(32'(wake), 32'h1);
      apb(0, `DCC_CTRL_OFS, 0);
      chk(rd, 32'h85);
      sleeping <= 0;
      $display("flag test done");
      apb(1, `DCC_PDIR_OFS, 32'hE7);
      // Global enable is off here, so the mode change raises no request.
      apb(1, `DCC_CTRL_OFS, 32'h16);
      repeat (4) @(posedge pclk);
      chk(32'(poe), 32'h3);
      chk(32'(pout), 32'h3);
      vpos <= 16'h0000;
      apb(1, `DCC_PDIR_OFS, 32'hEF);
      repeat (4) @(posedge pclk);
      chk(32'(pout), 32'h1);
      chk(32'(poe), 32'h2);
      apb(0, 12'h0F0, 0);
      chk({rd[30:0], err}, 32'h1);
      $display("pin test done");
      report_and_stop();
   end
endmodule
